// *** inc/ifd_map.vh ***
// Purpose: constants of the instruction field decoder
// Assumes: included by the rtl files by bare name
// Notes:   register offsets are byte addresses on the bus
`ifndef IFD_MAP_VH
`define IFD_MAP_VH
// register byte offsets (haddr[7:0])
`define IFD_OFF_CTRL  8'h00
`define IFD_OFF_BANK  8'h04
`define IFD_OFF_TPTR  8'h08
`define IFD_OFF_TLAT  8'h0c
`define IFD_OFF_FLAGS 8'h10
`define IFD_OFF_STAT  8'h14
`define IFD_OFF_PAIR  8'h18
// reset values
`define IFD_RST_CTRL  1'h0
`define IFD_RST_BANK  4'h0
`define IFD_RST_TPTR  21'h000000
`define IFD_RST_TLAT  8'h00
`define IFD_RST_FLAGS 5'h00
// field positions
`define IFD_CTRL_EN   0
`define IFD_FLG_C     0
`define IFD_FLG_DIG   1
`define IFD_FLG_Z     2
`define IFD_FLG_OVF   3
`define IFD_FLG_N     4
// decoded classes
`define IFD_CLS_NOP   4'h0
`define IFD_CLS_BYTE  4'h1
`define IFD_CLS_BIT   4'h2
`define IFD_CLS_LIT   4'h3
`define IFD_CLS_F2F   4'h4
`define IFD_CLS_JUMP  4'h5
`define IFD_CLS_CALL  4'h6
`define IFD_CLS_BRL   4'h7
`define IFD_CLS_BCND  4'h8
`define IFD_CLS_TBL   4'h9
`define IFD_CLS_RET   4'ha
`define IFD_CLS_LPTR  4'hb
`define IFD_CLS_IDX   4'hc
`define IFD_CLS_OTHER 4'hd
// table pointer modes
`define IFD_TM_NONE   2'h0
`define IFD_TM_POSTI  2'h1
`define IFD_TM_POSTD  2'h2
`define IFD_TM_PREI   2'h3
// second-word marker, access bank split, timing
`define IFD_SECOND    4'hf
`define IFD_ACC_SPLIT 8'h80
`define IFD_ACC_HIGH  4'hf
`define IFD_OSC_PER_CYC 3'h4
`define IFD_Q_LAST    2'h3
`endif

// *** rtl/ifd_decoder.v ***
// Purpose: instruction field decoder with AHB-Lite register slave
// Assumes: hclk is the oscillator; four of its periods make one
//          instruction cycle; fetched words arrive on fetch_word
// Notes:   all outputs but hresp, which is tied low, come from flip-flops
`timescale 1ns/1ns
`include "ifd_map.vh"
module ifd_decoder #(
  parameter BANK_W = 4
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire [31:0] hrdata,
  output wire        hresp,
  input  wire [15:0] fetch_word,
  input  wire        fetch_valid,
  output wire        fetch_taken,
  input  wire [7:0]  table_mem_rdata,
  input  wire        table_mem_rvalid,
  output wire [20:0] table_mem_addr,
  output wire        table_mem_rd,
  output wire        table_mem_wr,
  output wire [7:0]  table_mem_wdata,
  input  wire [4:0]  alu_flags,
  input  wire        alu_flags_valid,
  output wire        dec_valid,
  output wire [3:0]  dec_class,
  output wire        dec_to_accum,
  output wire        dec_to_file,
  output wire [11:0] dec_dmem_addr,
  output wire [7:0]  dec_bit_sel,
  output wire [7:0]  dec_literal,
  output wire [11:0] dec_src_addr,
  output wire [11:0] dec_dst_addr,
  output wire [19:0] dec_target,
  output wire [20:0] dec_offset,
  output wire        dec_fast,
  output wire [2:0]  dec_cond,
  output wire [1:0]  dec_ptr_sel,
  output wire [4:0]  dec_flag_mask,
  output wire [1:0]  dec_cycles,
  output wire [4:0]  status_flags
);
  // bus slave state
  reg              hreadyout_reg;
  reg [31:0]       hrdata_reg;
  reg              wr_pend_reg;
  reg              rd_pend_reg;
  reg [7:0]        addr_reg;
  reg [31:0]       rdata_next;
  // software visible state
  reg              ctrl_en_reg;
  reg [BANK_W-1:0] bank_reg;
  reg [20:0]       tptr_reg;
  reg [7:0]        tlat_reg;
  reg [4:0]        flags_reg;
  // sequencing state
  reg [1:0]        q_reg;
  reg              pend_reg;
  reg [15:0]       first_reg;
  reg              fetch_taken_reg;
  reg [20:0]       tm_addr_reg;
  reg              tm_rd_reg;
  reg              tm_wr_reg;
  // decoded outputs
  reg              dv_reg;
  reg [3:0]        cls_reg;
  reg              acc_reg;
  reg              file_reg;
  reg [11:0]       dmem_reg;
  reg [7:0]        bsel_reg;
  reg [7:0]        lit_reg;
  reg [11:0]       src_reg;
  reg [11:0]       dst_reg;
  reg [19:0]       tgt_reg;
  reg [20:0]       off_reg;
  reg              fast_reg;
  reg [2:0]        cond_reg;
  reg [1:0]        psel_reg;
  reg [4:0]        mask_reg;
  reg [1:0]        cyc_reg;
  // next values of the decoded outputs
  reg              out_next;
  reg              pend_next;
  reg [3:0]        cls_next;
  reg [11:0]       src_next;
  reg [11:0]       dst_next;
  reg [19:0]       tgt_next;
  reg [11:0]       dmem_next;
  reg [20:0]       tptr_next;
  reg [20:0]       tm_addr_next;

  wire        ap_take;
  wire        take;
  wire        pair_ok;
  wire [3:0]  c_cls;
  wire        c_two;
  wire [1:0]  c_cyc;
  wire [4:0]  c_mask;
  wire        c_fast;
  wire [20:0] c_off;
  wire        c_d;
  wire        c_a;
  wire [2:0]  c_bit;
  wire [1:0]  c_tm;
  wire        c_tw;
  wire [2:0]  c_cond;
  wire [1:0]  c_psel;
  wire [3:0]  f_cls;
  wire        f_fast;

  // current fetched word
  ifd_fields u_cur (
    .word       (fetch_word),
    .cls        (c_cls),
    .two_word   (c_two),
    .cycles     (c_cyc),
    .flag_mask  (c_mask),
    .fast       (c_fast),
    .offset     (c_off),
    .dest_bit   (c_d),
    .access_bit (c_a),
    .bit_num    (c_bit),
    .tmode      (c_tm),
    .twrite     (c_tw),
    .cond       (c_cond),
    .ptr_sel    (c_psel)
  );

  // held first word of a two-word instruction
  ifd_fields u_first (
    .word       (first_reg),
    .cls        (f_cls),
    .two_word   (),
    .cycles     (),
    .flag_mask  (),
    .fast       (f_fast),
    .offset     (),
    .dest_bit   (),
    .access_bit (),
    .bit_num    (),
    .tmode      (),
    .twrite     (),
    .cond       (),
    .ptr_sel    ()
  );

  // a word is taken only at the last quarter of an instruction cycle
  assign take    = (q_reg == `IFD_Q_LAST) & fetch_valid & ctrl_en_reg;
  assign pair_ok = pend_reg & (fetch_word[15:12] == `IFD_SECOND);
  assign ap_take = hsel & htrans[1] & hready;

  // combine current word, or the held pair, into next decoded values
  always @* begin
    out_next  = 1'b0;
    pend_next = pend_reg;
    cls_next  = c_cls;
    src_next  = 12'h000;
    dst_next  = 12'h000;
    tgt_next  = 20'h00000;
    if (take) begin
      if (pair_ok) begin
        out_next  = 1'b1;
        pend_next = 1'b0;
        cls_next  = f_cls;
        case (f_cls)
          `IFD_CLS_F2F: begin
            src_next = first_reg[11:0];
            dst_next = fetch_word[11:0];
          end
          `IFD_CLS_JUMP, `IFD_CLS_CALL:
            tgt_next = {fetch_word[11:0], first_reg[7:0]};
          `IFD_CLS_LPTR:
            tgt_next = {8'h00, first_reg[3:0], fetch_word[7:0]};
          `IFD_CLS_IDX: begin
            src_next = {5'h00, first_reg[6:0]};
            if (first_reg[7])
              dst_next = {5'h00, fetch_word[6:0]};
            else
              dst_next = fetch_word[11:0];
          end
          default: src_next = 12'h000;
        endcase
      end else begin
        // an unpaired first word is dropped; a lone 1111 word is a no-op
        pend_next = c_two;
        out_next  = ~c_two;
      end
    end
  end

  // data memory address: access bank or bank register above the file byte
  always @* begin
    if (c_a)
      dmem_next = {bank_reg, fetch_word[7:0]};
    else if (fetch_word[7:0] < `IFD_ACC_SPLIT)
      dmem_next = {4'h0, fetch_word[7:0]};
    else
      dmem_next = {`IFD_ACC_HIGH, fetch_word[7:0]};
  end

  // table pointer behaviour per mode; pre-increment addresses the new value
  always @* begin
    case (c_tm)
      `IFD_TM_POSTI: tptr_next = tptr_reg + 21'h000001;
      `IFD_TM_POSTD: tptr_next = tptr_reg - 21'h000001;
      `IFD_TM_PREI:  tptr_next = tptr_reg + 21'h000001;
      default:       tptr_next = tptr_reg;
    endcase
    tm_addr_next = (c_tm == `IFD_TM_PREI) ? tptr_next : tptr_reg;
  end

  // register read mux; unmapped offsets read as zero
  always @* begin
    case (addr_reg)
      `IFD_OFF_CTRL:  rdata_next = {31'h0, ctrl_en_reg};
      `IFD_OFF_BANK:  rdata_next = {{(32-BANK_W){1'b0}}, bank_reg};
      `IFD_OFF_TPTR:  rdata_next = {11'h000, tptr_reg};
      `IFD_OFF_TLAT:  rdata_next = {24'h000000, tlat_reg};
      `IFD_OFF_FLAGS: rdata_next = {27'h0, flags_reg};
      `IFD_OFF_STAT:  rdata_next = {24'h0, cls_reg, q_reg, 1'b0, pend_reg};
      `IFD_OFF_PAIR:  rdata_next = {first_reg, 16'h0000};
      default:        rdata_next = 32'h00000000;
    endcase
  end

  // bus slave: writes take no wait, reads take one wait state so they
  // always see a write made in the transfer just before
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hrdata_reg    <= 32'h00000000;
      wr_pend_reg   <= 1'b0;
      rd_pend_reg   <= 1'b0;
      addr_reg      <= 8'h00;
    end else if (rd_pend_reg) begin
      hrdata_reg    <= rdata_next;
      hreadyout_reg <= 1'b1;
      rd_pend_reg   <= 1'b0;
      wr_pend_reg   <= 1'b0;
    end else begin
      wr_pend_reg   <= ap_take & hwrite;
      rd_pend_reg   <= ap_take & ~hwrite;
      hreadyout_reg <= ~(ap_take & ~hwrite);
      if (ap_take)
        addr_reg <= haddr[7:0];
    end
  end

  // software registers; hardware updates land after bus writes and win
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_reg <= `IFD_RST_CTRL;
      bank_reg    <= `IFD_RST_BANK;
      tptr_reg    <= `IFD_RST_TPTR;
      tlat_reg    <= `IFD_RST_TLAT;
      flags_reg   <= `IFD_RST_FLAGS;
    end else begin
      if (wr_pend_reg) begin
        case (addr_reg)
          `IFD_OFF_CTRL:  ctrl_en_reg <= hwdata[`IFD_CTRL_EN];
          `IFD_OFF_BANK:  bank_reg    <= hwdata[BANK_W-1:0];
          `IFD_OFF_TPTR:  tptr_reg    <= hwdata[20:0];
          `IFD_OFF_TLAT:  tlat_reg    <= hwdata[7:0];
          `IFD_OFF_FLAGS: flags_reg   <= hwdata[4:0];
          default:        ctrl_en_reg <= ctrl_en_reg;
        endcase
      end
      if (take & (c_cls == `IFD_CLS_TBL))
        tptr_reg <= tptr_next;
      if (table_mem_rvalid)
        tlat_reg <= table_mem_rdata;
      // only the flags the last decoded instruction touches may change
      if (alu_flags_valid)
        flags_reg <= (flags_reg & ~mask_reg) | (alu_flags & mask_reg);
    end
  end

  // quarter counter and two-word pairing
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_reg           <= 2'h0;
      pend_reg        <= 1'b0;
      first_reg       <= 16'h0000;
      fetch_taken_reg <= 1'b0;
    end else begin
      q_reg           <= q_reg + 2'h1;
      fetch_taken_reg <= take;
      pend_reg        <= pend_next;
      if (take & ~pair_ok)
        first_reg <= fetch_word;
    end
  end

  // table memory strobes, one-cycle pulses
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tm_addr_reg <= 21'h000000;
      tm_rd_reg   <= 1'b0;
      tm_wr_reg   <= 1'b0;
    end else begin
      tm_rd_reg <= 1'b0;
      tm_wr_reg <= 1'b0;
      if (take & (c_cls == `IFD_CLS_TBL)) begin
        tm_addr_reg <= tm_addr_next;
        tm_rd_reg   <= ~c_tw;
        tm_wr_reg   <= c_tw;
      end
    end
  end

  // decoded fields, held until the next instruction completes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dv_reg   <= 1'b0;
      cls_reg  <= `IFD_CLS_NOP;
      acc_reg  <= 1'b0;
      file_reg <= 1'b0;
      dmem_reg <= 12'h000;
      bsel_reg <= 8'h00;
      lit_reg  <= 8'h00;
      src_reg  <= 12'h000;
      dst_reg  <= 12'h000;
      tgt_reg  <= 20'h00000;
      off_reg  <= 21'h000000;
      fast_reg <= 1'b0;
      cond_reg <= 3'h0;
      psel_reg <= 2'h0;
      mask_reg <= 5'h00;
      cyc_reg  <= 2'h0;
    end else begin
      dv_reg <= out_next;
      if (out_next) begin
        cls_reg  <= cls_next;
        src_reg  <= src_next;
        dst_reg  <= dst_next;
        tgt_reg  <= tgt_next;
        psel_reg <= pair_ok ? first_reg[5:4] : c_psel;
        if (pair_ok) begin
          fast_reg <= f_fast;
          cyc_reg  <= 2'h2;
          mask_reg <= 5'h00;
          acc_reg  <= 1'b0;
          file_reg <= 1'b0;
        end else begin
          fast_reg <= c_fast;
          cyc_reg  <= c_cyc;
          mask_reg <= c_mask;
          acc_reg  <= (c_cls == `IFD_CLS_BYTE) & ~c_d;
          file_reg <= (c_cls == `IFD_CLS_BYTE) & c_d;
          dmem_reg <= dmem_next;
          bsel_reg <= 8'h01 << c_bit;
          lit_reg  <= fetch_word[7:0];
          off_reg  <= c_off;
          cond_reg <= c_cond;
        end
      end
    end
  end

  assign hreadyout       = hreadyout_reg;
  assign hrdata          = hrdata_reg;
  assign hresp           = 1'b0;
  assign fetch_taken     = fetch_taken_reg;
  assign table_mem_addr  = tm_addr_reg;
  assign table_mem_rd    = tm_rd_reg;
  assign table_mem_wr    = tm_wr_reg;
  assign table_mem_wdata = tlat_reg;
  assign dec_valid       = dv_reg;
  assign dec_class       = cls_reg;
  assign dec_to_accum    = acc_reg;
  assign dec_to_file     = file_reg;
  assign dec_dmem_addr   = dmem_reg;
  assign dec_bit_sel     = bsel_reg;
  assign dec_literal     = lit_reg;
  assign dec_src_addr    = src_reg;
  assign dec_dst_addr    = dst_reg;
  assign dec_target      = tgt_reg;
  assign dec_offset      = off_reg;
  assign dec_fast        = fast_reg;
  assign dec_cond        = cond_reg;
  assign dec_ptr_sel     = psel_reg;
  assign dec_flag_mask   = mask_reg;
  assign dec_cycles      = cyc_reg;
  assign status_flags    = flags_reg;
endmodule // ifd_decoder

// *** rtl/ifd_fields.v ***
// Purpose: split one 16-bit word into class and operand fields
// Assumes: purely combinational, word is stable
// Notes:   only defined bits steer the decode
`timescale 1ns/1ns
`include "ifd_map.vh"
module ifd_fields (
  input  wire [15:0] word,
  output reg  [3:0]  cls,
  output reg         two_word,
  output reg  [1:0]  cycles,
  output reg  [4:0]  flag_mask,
  output reg         fast,
  output reg  [20:0] offset,
  output wire        dest_bit,
  output wire        access_bit,
  output wire [2:0]  bit_num,
  output wire [1:0]  tmode,
  output wire        twrite,
  output wire [2:0]  cond,
  output wire [1:0]  ptr_sel
);
  assign dest_bit   = word[9];
  assign access_bit = word[8];
  assign bit_num    = word[11:9];
  assign tmode      = word[1:0];
  assign twrite     = word[2];
  assign cond       = word[10:8];
  assign ptr_sel    = word[5:4];
  // class decode; x bits never appear in a match term
  always @* begin
    cls       = `IFD_CLS_OTHER;
    two_word  = 1'b0;
    cycles    = 2'h1;
    flag_mask = 5'h00;
    fast      = 1'b0;
    offset    = 21'h000000;
    casez (word[15:8])
      8'b0000_0000: begin
        if (word[7:3] == 5'b00001) begin
          cls    = `IFD_CLS_TBL;
          cycles = 2'h2;
        end else if (word[7:1] == 7'b0001000 || word[7:1] == 7'b0001001) begin
          cls    = `IFD_CLS_RET;
          fast   = word[0];
          cycles = 2'h2;
        end else if (word[7:0] == 8'h00) begin
          cls = `IFD_CLS_NOP;
        end
      end
      8'b0000_0001, 8'b0000_1???: cls = `IFD_CLS_LIT;
      8'b0111_????, 8'b10??_????: cls = `IFD_CLS_BIT;
      8'b0000_001?, 8'b0000_01??, 8'b0001_????, 8'b001?_????, 8'b010?_????,
      8'b0110_????: cls = `IFD_CLS_BYTE;
      8'b1100_????: begin
        cls      = `IFD_CLS_F2F;
        two_word = 1'b1;
        cycles   = 2'h2;
      end
      8'b1101_????: begin
        cls    = `IFD_CLS_BRL;
        cycles = 2'h2;
        offset = {{10{word[10]}}, word[10:0]};
      end
      8'b1110_0???: begin
        cls    = `IFD_CLS_BCND;
        offset = {{13{word[7]}}, word[7:0]};
      end
      8'b1110_110?: begin
        cls      = `IFD_CLS_CALL;
        fast     = word[8];
        two_word = 1'b1;
        cycles   = 2'h2;
      end
      8'b1110_1111: begin
        cls      = `IFD_CLS_JUMP;
        two_word = 1'b1;
        cycles   = 2'h2;
      end
      8'b1110_1110: begin
        if (word[7:6] == 2'h0) begin
          cls      = `IFD_CLS_LPTR;
          two_word = 1'b1;
          cycles   = 2'h2;
        end
      end
      8'b1110_1011: begin
        cls      = `IFD_CLS_IDX;
        two_word = 1'b1;
        cycles   = 2'h2;
      end
      8'b1111_????: cls = `IFD_CLS_NOP;
      default: cls = `IFD_CLS_OTHER;
    endcase
    // flags each byte operation touches
    if (cls == `IFD_CLS_BYTE) begin
      case (word[15:10])
        6'b001001, 6'b001000, 6'b010101, 6'b010111, 6'b010110, 6'b001010,
        6'b000001: flag_mask = 5'h1f;
        6'b001101, 6'b001100: flag_mask = 5'h15;
        6'b000101, 6'b000111, 6'b000100, 6'b010100, 6'b010001, 6'b010000,
        6'b000110: flag_mask = 5'h14;
        6'b011010: flag_mask = (word[9] == 1'b1) ? 5'h04 : 5'h00;
        6'b011011: flag_mask = (word[9] == 1'b1) ? 5'h00 : 5'h1f;
        default: flag_mask = 5'h00;
      endcase
    end
  end
endmodule // ifd_fields

// *** sim/ifd_prog_mem.sv ***
// Purpose: program memory feeding words and answering table reads
// Assumes: a word is held until the core signals it was taken
// Notes:   lag slows both answers; released lines show a changing value
`timescale 1ns/1ns
module ifd_prog_mem (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        push,
  input  wire [15:0] push_word,
  input  wire [3:0]  lag,
  input  wire        fetch_taken,
  input  wire        table_mem_rd,
  input  wire [20:0] table_mem_addr,
  output reg  [15:0] fetch_word,
  output reg         fetch_valid,
  output reg  [7:0]  table_mem_rdata,
  output reg         table_mem_rvalid
);
  reg [15:0] held;
  reg [3:0]  wcnt;
  reg        pend;
  reg [3:0]  tcnt;
  reg        tbusy;
  // word path: garbage while waiting so a early take shows up
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_valid <= 1'b0;
      fetch_word  <= 16'h0000;
      pend        <= 1'b0;
      wcnt        <= 4'h0;
      held        <= 16'h0000;
    end else if (push) begin
      held <= push_word;
      wcnt <= lag;
      pend <= 1'b1;
    end else if (pend && wcnt != 4'h0) begin
      wcnt       <= wcnt - 4'h1;
      fetch_word <= fetch_word + 16'h1357;
    end else if (pend) begin
      fetch_word  <= held;
      fetch_valid <= 1'b1;
      pend        <= 1'b0;
    end else if (fetch_valid && fetch_taken) begin
      fetch_valid <= 1'b0;
      fetch_word  <= ~fetch_word;
    end
  end
  // table read answer: data is the low address byte scrambled
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tbusy            <= 1'b0;
      tcnt             <= 4'h0;
      table_mem_rvalid <= 1'b0;
      table_mem_rdata  <= 8'h00;
    end else begin
      table_mem_rvalid <= 1'b0;
      table_mem_rdata  <= ~table_mem_rdata;
      if (table_mem_rd) begin
        tbusy <= 1'b1;
        tcnt  <= lag;
      end else if (tbusy && tcnt != 4'h0) begin
        tcnt <= tcnt - 4'h1;
      end else if (tbusy) begin
        tbusy            <= 1'b0;
        table_mem_rvalid <= 1'b1;
        table_mem_rdata  <= table_mem_addr[7:0] ^ 8'ha5;
      end
    end
  end
endmodule // ifd_prog_mem

// *** sim/ifd_properties.sv ***
// Purpose: port checks of the instruction field decoder
// Assumes: one clock domain, hresetn low clears all
// Notes:   fields of a decode are tied to the word taken one edge earlier
`timescale 1ns/1ns
`include "ifd_map.vh"
module ifd_properties (
  input wire        hclk,
  input wire        hresetn,
  input wire [15:0] fetch_word,
  input wire        fetch_taken,
  input wire        table_mem_rd,
  input wire        table_mem_wr,
  input wire [4:0]  alu_flags,
  input wire        alu_flags_valid,
  input wire        dec_valid,
  input wire [3:0]  dec_class,
  input wire        dec_to_accum,
  input wire        dec_to_file,
  input wire [7:0]  dec_bit_sel,
  input wire [7:0]  dec_literal,
  input wire [20:0] dec_offset,
  input wire [4:0]  dec_flag_mask,
  input wire [4:0]  status_flags
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // decode fields against the word taken at the previous edge
  dest_route_a: assert property (dec_valid |->
    ((dec_to_accum ^ dec_to_file) == (dec_class == `IFD_CLS_BYTE))) else $error("dest route");
  bit_select_a: assert property (dec_valid && dec_class == `IFD_CLS_BIT |->
    dec_bit_sel == (8'h01 << $past(fetch_word[11:9]))) else $error("bit select");
  literal_byte_a: assert property (dec_valid && dec_class != 4'h0 &&
    dec_class <= `IFD_CLS_LIT |-> dec_literal == $past(fetch_word[7:0])) else $error("literal");
  long_offset_a: assert property (dec_valid && dec_class == `IFD_CLS_BRL |->
    dec_offset == {{10{$past(fetch_word[10])}}, $past(fetch_word[10:0])}) else $error("long offset");
  cond_offset_a: assert property (dec_valid && dec_class == `IFD_CLS_BCND |->
    dec_offset == {{13{$past(fetch_word[7])}}, $past(fetch_word[7:0])}) else $error("cond offset");
  // one take per instruction cycle of four clocks
  fetch_spacing_a: assert property (fetch_taken |=> (!fetch_taken) [*3])
    else $error("fetch spacing");
  table_strobe_a: assert property (table_mem_rd || table_mem_wr |->
    fetch_taken && !(table_mem_rd && table_mem_wr)) else $error("table strobe");
  // only the flags named by the last decode may move
  flag_merge_a: assert property (alu_flags_valid |=> status_flags ==
    (($past(status_flags) & ~$past(dec_flag_mask)) | ($past(alu_flags) & $past(dec_flag_mask))))
    else $error("flag merge");
endmodule // ifd_properties

bind ifd_decoder ifd_properties chk_u (.hclk, .hresetn, .fetch_word, .fetch_taken,
  .table_mem_rd, .table_mem_wr, .alu_flags, .alu_flags_valid, .dec_valid, .dec_class,
  .dec_to_accum, .dec_to_file, .dec_bit_sel, .dec_literal, .dec_offset, .dec_flag_mask,
  .status_flags);

// *** sim/ifd_tb.sv ***
// Purpose: self-checking bench of the instruction field decoder
// Assumes: bus slave answers reads after one wait state
// Notes:   each scenario judges its own results
`timescale 1ns/1ns
`include "ifd_map.vh"
module testbench;
  reg         hclk, hresetn, hsel, hwrite, push, alu_flags_valid;
  reg  [31:0] haddr, hwdata;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  reg  [15:0] push_word;
  reg  [3:0]  lag;
  reg  [4:0]  alu_flags;
  integer     errors, num_checks;
  wire        hready, hreadyout, hresp, fetch_valid, fetch_taken, table_mem_rvalid;
  wire        table_mem_rd, table_mem_wr, dec_valid, dec_to_accum, dec_to_file, dec_fast;
  wire [31:0] hrdata;
  wire [15:0] fetch_word;
  wire [7:0]  table_mem_rdata, table_mem_wdata, dec_bit_sel, dec_literal;
  wire [20:0] table_mem_addr, dec_offset;
  wire [3:0]  dec_class;
  wire [11:0] dec_dmem_addr, dec_src_addr, dec_dst_addr;
  wire [19:0] dec_target;
  wire [2:0]  dec_cond;
  wire [1:0]  dec_ptr_sel, dec_cycles;
  wire [4:0]  dec_flag_mask, status_flags;
  assign hready = hreadyout;
  ifd_decoder dut_u (.*);
  ifd_prog_mem pm_u (.*);
  always #50 hclk = ~hclk;
  task end_of_test;
    begin
      if (errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // bounded waits; a limit that runs out is a mismatch
  task wait_rdy;
    integer n;
    begin
      @(posedge hclk);
      for (n = 0; hreadyout !== 1'b1 && n < 50; n = n + 1)
        @(posedge hclk);
      check({hresp, hreadyout}, 2'b01);
    end
  endtask
  task bus(input wr, input [7:0] a, input [31:0] d, output [31:0] q);
    begin
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_rdy;
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      q = hrdata;
    end
  endtask
  task bus_wr(input [7:0] a, input [31:0] d);
    reg [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
    reg [31:0] q;
    begin
      bus(1'b0, a, 32'h0, q);
      check(q, e);
    end
  endtask
  task fetch(input [15:0] w);
    integer n;
    begin
      push      <= 1'b1;
      push_word <= w;
      @(posedge hclk);
      push <= 1'b0;
      for (n = 0; fetch_taken !== 1'b1 && n < 40; n = n + 1)
        @(posedge hclk);
      check(fetch_taken, 1);
    end
  endtask
  task dec(input [15:0] w, input [3:0] c);
    begin
      fetch(w);
      check(dec_valid, 1);
      check(dec_class, c);
    end
  endtask
  task t_regs;
    begin
      rd_chk(`IFD_OFF_CTRL, `IFD_RST_CTRL);
      rd_chk(`IFD_OFF_BANK, `IFD_RST_BANK);
      rd_chk(`IFD_OFF_TPTR, `IFD_RST_TPTR);
      rd_chk(`IFD_OFF_TLAT, `IFD_RST_TLAT);
      rd_chk(`IFD_OFF_FLAGS, `IFD_RST_FLAGS);
      bus_wr(8'h40, 32'hffffffff);
      rd_chk(8'h40, 32'h0);
      bus_wr(`IFD_OFF_BANK, 32'h5);
      rd_chk(`IFD_OFF_BANK, 32'h5);
      bus_wr(`IFD_OFF_CTRL, 32'h1);
    end
  endtask
  task t_byte;
    begin
      dec(16'h27a3, `IFD_CLS_BYTE);
      check({dec_to_accum, dec_to_file}, 2'b01);
      check(dec_dmem_addr, 12'h5a3);
      check(dec_cycles, 1);
      dec(16'h2412, `IFD_CLS_BYTE);
      check({dec_to_accum, dec_to_file}, 2'b10);
      check(dec_dmem_addr, 12'h012);
      dec(16'h24c0, `IFD_CLS_BYTE);
      check(dec_dmem_addr, 12'hfc0);
      dec(16'h0e7f, `IFD_CLS_LIT);
      check(dec_literal, 8'h7f);
    end
  endtask
  task t_bits;
    integer i;
    for (i = 0; i < 8; i = i + 1) begin
      dec({4'h8, i[2:0], 1'b0, 8'h44}, `IFD_CLS_BIT);
      check(dec_bit_sel, 8'h01 << i);
    end
  endtask
  // slow memory: pairs must survive gaps between the two words
  task t_pairs;
    begin
      lag <= 4'h3;
      fetch(16'hef12);
      check(dec_valid, 0);
      dec(16'hf345, `IFD_CLS_JUMP);
      check(dec_target, 20'h34512);
      check(dec_cycles, 2);
      fetch(16'hed34);
      dec(16'hf0ab, `IFD_CLS_CALL);
      check({dec_fast, dec_target}, 21'h10ab34);
      fetch(16'hec34);
      dec(16'hf0ab, `IFD_CLS_CALL);
      check(dec_fast, 0);
      dec(16'h0013, `IFD_CLS_RET);
      check(dec_fast, 1);
      fetch(16'hc123);
      dec(16'hf456, `IFD_CLS_F2F);
      check({dec_src_addr, dec_dst_addr}, 24'h123456);
      fetch(16'heb05);
      dec(16'hf123, `IFD_CLS_IDX);
      check({dec_src_addr, dec_dst_addr}, 24'h005123);
      fetch(16'hee2a);
      dec(16'hf0bc, `IFD_CLS_LPTR);
      check({dec_ptr_sel, dec_target}, 22'h200abc);
      dec(16'hf999, `IFD_CLS_NOP);
      dec(16'hf000, `IFD_CLS_NOP);
      fetch(16'hef12);
      dec(16'h27a3, `IFD_CLS_BYTE);
      lag <= 4'h1;
    end
  endtask
  task t_branch;
    begin
      dec(16'hd400, `IFD_CLS_BRL);
      check(dec_offset, 21'h1ffc00);
      dec(16'hd3ff, `IFD_CLS_BRL);
      check(dec_offset, 21'h0003ff);
      dec(16'he280, `IFD_CLS_BCND);
      check({dec_cond, dec_offset}, 24'h5fff80);
      dec(16'he27f, `IFD_CLS_BCND);
      check(dec_offset, 21'h00007f);
    end
  endtask
  // every pointer mode, a wrap at the top, and a latch write
  task t_table;
    integer m;
    reg [20:0] a;
    begin
      for (m = 0; m < 4; m = m + 1) begin
        a = (m == 3) ? 21'h000101 : 21'h000100;
        bus_wr(`IFD_OFF_TPTR, 32'h100);
        fetch({12'h000, 2'b10, m[1:0]});
        check({table_mem_rd, table_mem_addr}, {1'b1, a});
        rd_chk(`IFD_OFF_TPTR, (m == 0) ? 32'h100 : (m == 2) ? 32'hff : 32'h101);
        rd_chk(`IFD_OFF_TLAT, a[7:0] ^ 8'ha5);
      end
      bus_wr(`IFD_OFF_TPTR, 32'h1fffff);
      fetch(16'h0009);
      check(table_mem_addr, 21'h1fffff);
      rd_chk(`IFD_OFF_TPTR, 32'h0);
      bus_wr(`IFD_OFF_TLAT, 32'h3c);
      fetch(16'h000c);
      check({table_mem_wr, table_mem_wdata}, 9'h13c);
    end
  endtask
  task flags(input [4:0] f);
    begin
      alu_flags       <= f;
      alu_flags_valid <= 1'b1;
      @(posedge hclk);
      alu_flags_valid <= 1'b0;
      @(posedge hclk);
    end
  endtask
  task t_flags;
    begin
      dec(16'h27a3, `IFD_CLS_BYTE);
      check(dec_flag_mask, 5'h1f);
      flags(5'h15);
      check(status_flags, 5'h15);
      dec(16'h14a0, `IFD_CLS_BYTE);
      check(dec_flag_mask, 5'h14);
      flags(5'h0a);
      rd_chk(`IFD_OFF_FLAGS, 32'h01);
    end
  endtask
  initial begin
    #2000000;
    errors = errors + 1;
    end_of_test;
  end
  initial begin
    {hclk, hresetn, hsel, hwrite, push, alu_flags_valid} = 6'h00;
    {haddr, hwdata, htrans, push_word, alu_flags} = 87'h0;
    hsize = 3'h2;
    lag = 4'h1;
    errors = 0;
    num_checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_byte;
    t_bits;
    t_pairs;
    t_branch;
    t_table;
    t_flags;
    end_of_test;
  end
endmodule // testbench
